// ---- pkg/swt_regs.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  slow clock wakeup timer. Assumes byte offsets on an 8-bit address.
*/
`ifndef SWT_REGS_SVH
`define SWT_REGS_SVH

`define SWT_OFF_SETTLE 8'h08
`define SWT_OFF_TIME 8'h10
`define SWT_OFF_MIN 8'h14
`define SWT_OFF_MEAN 8'h18
`define SWT_OFF_MAX 8'h1c
`define SWT_OFF_STCLR 8'h20
`define SWT_OFF_RTIME 8'h24
`define SWT_OFF_RSLP 8'h28
`define SWT_OFF_CTIME 8'h2c
`define SWT_OFF_CSLP 8'h30
`define SWT_OFF_RMASK 8'h40
`define SWT_OFF_RFLAG 8'h44
`define SWT_OFF_CMASK 8'h48
`define SWT_OFF_CFLAG 8'h4c

`define SWT_CLR_EXT_BIT 0
`define SWT_CLR_MEAN_BIT 1
`define SWT_SLEEP_EN_BIT 29
`define SWT_WAKE_EN_BIT 30
`define SWT_FORCE_BIT 31
`define SWT_IRQ_BIT 0

`define SWT_RSLP_RST 32'h0000_0007
`define SWT_CSLP_RST 32'h8000_0007
`define SWT_SLP_WMASK 32'he000_0007

`define SWT_REF_MHZ 50
`define SWT_TICK_MHZ 16
`define SWT_AVG_WINDOW 4'hf
`define SWT_AVG_SAT 8'hff
`define SWT_FRAC_MAX 4'hf
`define SWT_LEN_MAX 10'h3ff

`endif

// ---- pkg/swt_pkg.sv ----
/*
  Types shared by the slow clock wakeup timer. Assumes swt_regs.svh holds
  the numeric constants.
*/
package swt_pkg;

  // wake requests leaving the block, one-cycle pulses
  typedef struct packed {
    logic supply_restore_req;
    logic radio_wake_req;
    logic core_wake_req;
  } swt_wake_t;

  // peripheral bus request
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } swt_bus_req_t;

endpackage

// ---- design/swt_wakeup_timer.sv ----
/*
  Slow clock wakeup timer: free running interpolated time, slow period
  statistics, timed wake requests, sleep requests and wake interrupt flags.
  Assumes ref_clk at 50 MHz, slow_clk an asynchronous pin near 32 kHz, and
  a peripheral bus master on ref_clk with zero wait states.
*/
// Overview of operation
// - An 8-bit settle lead time in slow periods is held by software.
// - Free time is 32 bits: 31:4 slow count, 3:0 interpolated fraction.
// - Smallest measured slow period shown in bits 13:4, bits 3:0 read zero.
// - Largest measured slow period shown in bits 13:4.
// - Mean integer part is 16 MHz cycles per slow period, updated every 16.
// - Bits 13:0 of mean give 16 MHz cycles within sixteen slow periods.
// - Bits 31:24 count averaged periods, each period, saturating at 0xff.
// - Writing one to bit 0 clears min and max; bit reads back zero.
// - Writing one to bit 1 clears mean and its count; bit reads back zero.
// - A 32-bit radio wake time in sixteenth slow periods is writable.
// - Sleep enable bit 29 requests low power when radio reports not busy.
// - Radio wake enable bit 30 arms wakeup and clears itself on match.
// - Force bit 31 treats the radio as always asleep.
// - Core wake time holds bits 31:4; bits 3:0 read zero.
// - Core wake enable bit 30 issues system wakeup on slow count match.
// - Core force bit 31 resets to one, treating the CPU as asleep.
// - Radio wake interrupt mask bit 0 gates the radio interrupt line.
// - Core wake interrupt mask bit 0 gates the core interrupt line.
// - Status bit 0 reads pending state and clears on write of one.
// - Supply restore raised at radio wake time minus settle lead.
// - Radio wakeup raised when slow count matches radio wake time 31:4.
// - The slow count is a 28-bit free running wrapping counter.
// - Fraction derives from slow clock and a 16 MHz reference tick.
`timescale 1ns/100ps
`include "swt_regs.svh"

module swt_wakeup_timer
  import swt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic slow_clk,
  input wire swt_bus_req_t bus_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic radio_not_busy,
  input wire logic cpu_sleep_req,
  output logic [31:0] free_time,
  output swt_wake_t wake,
  output logic radio_irq,
  output logic core_irq,
  output logic radio_lp_req,
  output logic radio_sleeping,
  output logic cpu_sleeping
);

  // slow count match with an optional lead in slow periods
  function automatic logic time_hit(input logic [27:0] now, input logic [27:0] target,
                                    input logic [7:0] lead);
    time_hit = (now == 28'(target - {20'h0, lead}));
  endfunction

  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // slow clock pin synchroniser and rising edge
  logic slow_meta_q, slow_sync_q, slow_prev_q;
  logic slow_rise;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_meta_q <= 1'b0;
      slow_sync_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      slow_meta_q <= slow_clk;
      slow_sync_q <= slow_meta_q;
      slow_prev_q <= slow_sync_q;
    end
  end
  assign slow_rise = slow_sync_q & ~slow_prev_q;

  // 16 MHz tick enable by fractional division of ref_clk
  logic [5:0] tick_acc_q;
  logic [6:0] tick_sum;
  logic tick_en;
  assign tick_sum = {1'b0, tick_acc_q} + 7'(`SWT_TICK_MHZ);
  assign tick_en = tick_sum >= 7'(`SWT_REF_MHZ);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) tick_acc_q <= 6'h00;
    else tick_acc_q <= tick_en ? 6'(tick_sum - 7'(`SWT_REF_MHZ)) : tick_sum[5:0];
  end

  // bus decode
  logic setup_ph, wr_acc;
  logic sel_settle, sel_time, sel_min, sel_mean, sel_max, sel_stclr;
  logic sel_rtime, sel_rslp, sel_ctime, sel_cslp, sel_rmask, sel_rflag, sel_cmask, sel_cflag;
  logic addr_hit;
  assign setup_ph = bus_req.sel & ~bus_req.enable;
  assign wr_acc = bus_req.sel & bus_req.enable & bus_req.write & pready;
  assign sel_settle = bus_req.addr == `SWT_OFF_SETTLE;
  assign sel_time = bus_req.addr == `SWT_OFF_TIME;
  assign sel_min = bus_req.addr == `SWT_OFF_MIN;
  assign sel_mean = bus_req.addr == `SWT_OFF_MEAN;
  assign sel_max = bus_req.addr == `SWT_OFF_MAX;
  assign sel_stclr = bus_req.addr == `SWT_OFF_STCLR;
  assign sel_rtime = bus_req.addr == `SWT_OFF_RTIME;
  assign sel_rslp = bus_req.addr == `SWT_OFF_RSLP;
  assign sel_ctime = bus_req.addr == `SWT_OFF_CTIME;
  assign sel_cslp = bus_req.addr == `SWT_OFF_CSLP;
  assign sel_rmask = bus_req.addr == `SWT_OFF_RMASK;
  assign sel_rflag = bus_req.addr == `SWT_OFF_RFLAG;
  assign sel_cmask = bus_req.addr == `SWT_OFF_CMASK;
  assign sel_cflag = bus_req.addr == `SWT_OFF_CFLAG;
  assign addr_hit = sel_settle | sel_time | sel_min | sel_mean | sel_max | sel_stclr |
                    sel_rtime | sel_rslp | sel_ctime | sel_cslp | sel_rmask | sel_rflag |
                    sel_cmask | sel_cflag;

  // clear of min and max, self clearing pulse
  logic clear_extremes;
  assign clear_extremes = wr_acc & sel_stclr & bus_req.wdata[`SWT_CLR_EXT_BIT];
  // clear of mean and its count, self clearing pulse
  logic clear_mean;
  assign clear_mean = wr_acc & sel_stclr & bus_req.wdata[`SWT_CLR_MEAN_BIT];

  // period length in 16 MHz ticks; first partial period is discarded
  logic [9:0] len_cnt_q, last_len_q;
  logic started_q, meas_valid;
  assign meas_valid = slow_rise & started_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      len_cnt_q <= 10'h000;
      last_len_q <= 10'h000;
      started_q <= 1'b0;
    end else if (slow_rise) begin
      started_q <= 1'b1;
      last_len_q <= len_cnt_q;
      len_cnt_q <= {9'h000, tick_en};
    end else if (tick_en && len_cnt_q != `SWT_LEN_MAX) begin
      len_cnt_q <= len_cnt_q + 10'h001;
    end
  end

  logic [9:0] min_q, max_q;
  logic ext_valid_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      min_q <= 10'h000;
      max_q <= 10'h000;
      ext_valid_q <= 1'b0;
    end else if (clear_extremes) begin
      min_q <= 10'h000;
      max_q <= 10'h000;
      ext_valid_q <= 1'b0;
    end else if (meas_valid) begin
      ext_valid_q <= 1'b1;
      if (!ext_valid_q || len_cnt_q < min_q) min_q <= len_cnt_q;
      if (!ext_valid_q || len_cnt_q > max_q) max_q <= len_cnt_q;
    end
  end

  // mean over windows of sixteen periods, saturating count
  logic [13:0] sum_q, mean_q, sum_next;
  logic [3:0] win_q;
  logic [7:0] avg_count_q;
  assign sum_next = sum_q + {4'h0, len_cnt_q};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_q <= 14'h0000;
      mean_q <= 14'h0000;
      win_q <= 4'h0;
      avg_count_q <= 8'h00;
    end else if (clear_mean) begin
      sum_q <= 14'h0000;
      mean_q <= 14'h0000;
      win_q <= 4'h0;
      avg_count_q <= 8'h00;
    end else if (meas_valid) begin
      win_q <= win_q + 4'h1;
      if (avg_count_q != `SWT_AVG_SAT) avg_count_q <= avg_count_q + 8'h01;
      if (win_q == `SWT_AVG_WINDOW) begin
        mean_q <= sum_next;
        sum_q <= 14'h0000;
      end else begin
        sum_q <= sum_next;
      end
    end
  end

  // fraction steps up to fifteen times per period, using mean or last length
  logic [9:0] divisor;
  logic [10:0] frac_acc_q, frac_sum;
  logic [3:0] frac_q;
  assign divisor = (mean_q[13:4] != 10'h000) ? mean_q[13:4] : last_len_q;
  assign frac_sum = frac_acc_q + 11'h010;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frac_acc_q <= 11'h000;
      frac_q <= 4'h0;
    end else if (slow_rise) begin
      frac_acc_q <= 11'h000;
      frac_q <= 4'h0;
    end else if (tick_en && divisor != 10'h000 && frac_q != `SWT_FRAC_MAX) begin
      if (frac_sum >= {1'b0, divisor}) begin
        frac_acc_q <= 11'(frac_sum - {1'b0, divisor});
        frac_q <= frac_q + 4'h1;
      end else begin
        frac_acc_q <= frac_sum;
      end
    end
  end

  logic [27:0] time_int_q;
  logic eval_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      time_int_q <= 28'h0000000;
      eval_q <= 1'b0;
    end else begin
      eval_q <= slow_rise;
      if (slow_rise) time_int_q <= time_int_q + 28'h0000001;
    end
  end
  assign free_time = {time_int_q, frac_q};

  // software registers
  logic [31:0] settle_q, rtime_q, rslp_q, cslp_q;
  logic [27:0] ctime_q;
  logic rmask_q, cmask_q, rflag_q, cflag_q;
  logic radio_hit, core_hit, settle_hit;
  // radio match, armed by wake enable
  assign radio_hit = eval_q & rslp_q[`SWT_WAKE_EN_BIT] &
                     time_hit(time_int_q, rtime_q[31:4], 8'h00);
  // core match while core wake enabled
  assign core_hit = eval_q & cslp_q[`SWT_WAKE_EN_BIT] &
                    time_hit(time_int_q, ctime_q, 8'h00);
  // early supply restore ahead by the settle lead
  assign settle_hit = eval_q & ((rslp_q[`SWT_WAKE_EN_BIT] &
                       time_hit(time_int_q, rtime_q[31:4], settle_q[7:0])) |
                      (cslp_q[`SWT_WAKE_EN_BIT] &
                       time_hit(time_int_q, ctime_q, settle_q[7:0])));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 32'h0000_0000;
      rtime_q <= 32'h0000_0000;
      ctime_q <= 28'h0000000;
    end else begin
      if (wr_acc && sel_settle) settle_q <= bus_req.wdata;
      if (wr_acc && sel_rtime) rtime_q <= bus_req.wdata;
      if (wr_acc && sel_ctime) ctime_q <= bus_req.wdata[31:4];
    end
  end

  // sleep control; hardware clears radio wake enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rslp_q <= `SWT_RSLP_RST;
      cslp_q <= `SWT_CSLP_RST;
    end else begin
      if (wr_acc && sel_rslp) rslp_q <= bus_req.wdata & `SWT_SLP_WMASK;
      else if (radio_hit) rslp_q[`SWT_WAKE_EN_BIT] <= 1'b0;
      if (wr_acc && sel_cslp) cslp_q <= bus_req.wdata & `SWT_SLP_WMASK;
    end
  end

  // sticky flags, a set in the clearing cycle wins
  logic rflag_d, cflag_d;
  assign rflag_d = radio_hit | (rflag_q & ~(wr_acc & sel_rflag & bus_req.wdata[`SWT_IRQ_BIT]));
  assign cflag_d = core_hit | (cflag_q & ~(wr_acc & sel_cflag & bus_req.wdata[`SWT_IRQ_BIT]));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rmask_q <= 1'b0;
      cmask_q <= 1'b0;
      rflag_q <= 1'b0;
      cflag_q <= 1'b0;
    end else begin
      if (wr_acc && sel_rmask) rmask_q <= bus_req.wdata[`SWT_IRQ_BIT];
      if (wr_acc && sel_cmask) cmask_q <= bus_req.wdata[`SWT_IRQ_BIT];
      rflag_q <= rflag_d;
      cflag_q <= cflag_d;
    end
  end

  // outputs to power controller, radio and CPU
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake <= '0;
      radio_irq <= 1'b0;
      core_irq <= 1'b0;
      radio_lp_req <= 1'b0;
      radio_sleeping <= 1'b0;
      cpu_sleeping <= 1'b0;
    end else begin
      wake.supply_restore_req <= settle_hit;
      wake.radio_wake_req <= radio_hit;
      wake.core_wake_req <= core_hit;
      radio_irq <= rflag_q & rmask_q;
      core_irq <= cflag_q & cmask_q;
      // low power request, relies on not busy meaning fully idle
      radio_lp_req <= rslp_q[`SWT_SLEEP_EN_BIT] & radio_not_busy;
      radio_sleeping <= rslp_q[`SWT_FORCE_BIT] | radio_lp_req;
      cpu_sleeping <= cslp_q[`SWT_FORCE_BIT] | cpu_sleep_req;
    end
  end

  // read mux, unmapped reads zero
  logic [31:0] rd_mux;
  always_comb begin
    if (sel_settle) rd_mux = settle_q;
    else if (sel_time) rd_mux = {time_int_q, frac_q};
    else if (sel_min) rd_mux = {18'h00000, min_q, 4'h0};
    else if (sel_mean) rd_mux = {avg_count_q, 10'h000, mean_q};
    else if (sel_max) rd_mux = {18'h00000, max_q, 4'h0};
    else if (sel_rtime) rd_mux = rtime_q;
    else if (sel_rslp) rd_mux = rslp_q;
    else if (sel_ctime) rd_mux = {ctime_q, 4'h0};
    else if (sel_cslp) rd_mux = cslp_q;
    else if (sel_rmask) rd_mux = {31'h0, rmask_q};
    else if (sel_rflag) rd_mux = {31'h0, rflag_q};
    else if (sel_cmask) rd_mux = {31'h0, cmask_q};
    else if (sel_cflag) rd_mux = {31'h0, cflag_q};
    else rd_mux = 32'h0000_0000;
  end

  // bus answer in the access cycle, error on unmapped address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~addr_hit;
      if (setup_ph) prdata <= bus_req.write ? 32'h0000_0000 : rd_mux;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  time_wraps_a: assert property (slow_rise |=> time_int_q == 28'($past(time_int_q) + 28'h1))
    else $error("slow count did not advance");
  frac_restart_a: assert property (slow_rise |=> frac_q == 4'h0)
    else $error("fraction not restarted on slow edge");
  avg_saturate_a: assert property (avg_count_q == `SWT_AVG_SAT && !clear_mean |=>
    avg_count_q == `SWT_AVG_SAT)
    else $error("average count wrapped");
  extreme_order_a: assert property (ext_valid_q |-> min_q <= max_q)
    else $error("minimum above maximum");
  clear_ext_a: assert property (clear_extremes |=> min_q == 10'h0 && max_q == 10'h0)
    else $error("extremes not cleared");
  clear_mean_a: assert property (clear_mean |=> avg_count_q == 8'h0 && mean_q == 14'h0)
    else $error("mean not cleared");
  radio_wake_a: assert property (radio_hit && !(wr_acc && sel_rslp) |=>
    wake.radio_wake_req && !rslp_q[`SWT_WAKE_EN_BIT])
    else $error("radio wake not raised or enable not cleared");
  settle_lead_a: assert property (eval_q && rslp_q[`SWT_WAKE_EN_BIT] &&
    time_int_q == 28'(rtime_q[31:4] - {20'h0, settle_q[7:0]}) |=>
    wake.supply_restore_req)
    else $error("supply restore missing at lead time");
  core_mask_a: assert property (wake.core_wake_req |-> $past(cslp_q[`SWT_WAKE_EN_BIT]))
    else $error("core wake while disabled");
  flag_set_a: assert property (radio_hit ##1 rmask_q |=> radio_irq)
    else $error("radio interrupt missing");
  irq_gate_a: assert property (core_irq |-> $past(cmask_q))
    else $error("core interrupt while masked");
  force_sleep_a: assert property (rslp_q[`SWT_FORCE_BIT] |=> radio_sleeping)
    else $error("forced radio sleep not shown");
  lp_req_a: assert property (!rslp_q[`SWT_SLEEP_EN_BIT] |=> !radio_lp_req)
    else $error("low power requested while disabled");

  radio_wake_c: cover property (radio_hit ##1 wake.radio_wake_req);
  core_wake_c: cover property (settle_hit ##[1:300] core_hit);
  mean_ready_c: cover property (meas_valid && win_q == `SWT_AVG_WINDOW);

endmodule // swt_wakeup_timer

// ---- test/swt_radio_seq_model.sv ----
/*
  Behavioural radio sequencer facing the wakeup timer.
  Assumes one ref_clk domain and a bench that drives the two timer enables.
*/
`timescale 1ns/100ps

module swt_radio_seq_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wake_req,
  input wire logic sequence_timer_one_en,
  input wire logic sequence_timer_two_en,
  input wire logic [7:0] seq_len,
  output logic radio_not_busy
);
  logic [7:0] seq_left_q;

  // a wake request starts one sequence of seq_len cycles
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_left_q <= 8'h00;
    end else if (wake_req) begin
      seq_left_q <= seq_len;
    end else if (seq_left_q != 8'h00) begin
      seq_left_q <= seq_left_q - 8'h01;
    end
  end

  assign radio_not_busy = (seq_left_q == 8'h00) && !sequence_timer_one_en &&
                          !sequence_timer_two_en;
endmodule // swt_radio_seq_model

// ---- test/slow_clock_wakeup_timer_test.sv ----
/*
  Self-checking bench of the slow clock wakeup timer.
  Assumes swt_regs.svh on the include path and a slow clock of 1 us period.
*/
`timescale 1ns/100ps
`include "swt_regs.svh"

module slow_clock_wakeup_timer_test
  import swt_pkg::*;
;
  logic ref_clk, reset_n, slow_clk, pready, pslverr, radio_not_busy, cpu_sleep_req;
  logic radio_irq, core_irq, radio_lp_req, radio_sleeping, cpu_sleeping, err;
  logic sequence_timer_one_en, sequence_timer_two_en;
  logic [31:0] prdata, free_time, q;
  logic [27:0] tgt;
  swt_bus_req_t bus_req;
  swt_wake_t wake;
  int errors, tests_run;
  localparam logic [7:0] RST_OFF [13] = '{`SWT_OFF_MIN, `SWT_OFF_MEAN, `SWT_OFF_MAX,
    `SWT_OFF_SETTLE, `SWT_OFF_STCLR, `SWT_OFF_RTIME, `SWT_OFF_RSLP, `SWT_OFF_CTIME,
    `SWT_OFF_CSLP, `SWT_OFF_RMASK, `SWT_OFF_RFLAG, `SWT_OFF_CMASK, `SWT_OFF_CFLAG};
  localparam logic [31:0] RST_VAL [13] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    `SWT_RSLP_RST, 32'h0, `SWT_CSLP_RST, 32'h0, 32'h0, 32'h0, 32'h0};

  swt_wakeup_timer dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .slow_clk(slow_clk),
    .bus_req(bus_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .radio_not_busy(radio_not_busy), .cpu_sleep_req(cpu_sleep_req),
    .free_time(free_time), .wake(wake), .radio_irq(radio_irq), .core_irq(core_irq),
    .radio_lp_req(radio_lp_req), .radio_sleeping(radio_sleeping),
    .cpu_sleeping(cpu_sleeping));

  swt_radio_seq_model seq_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .wake_req(wake.radio_wake_req), .sequence_timer_one_en(sequence_timer_one_en),
    .sequence_timer_two_en(sequence_timer_two_en), .seq_len(8'h14),
    .radio_not_busy(radio_not_busy));

  // clocks: 50 MHz system, 1 MHz slow so 16 reference ticks per period
  always #10 ref_clk = ~ref_clk;
  always #500 slow_clk = ~slow_clk;

  task automatic close_out();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // wait n edges, then let the edge updates settle
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // setup, access until pready, release on the edge that saw pready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    @(posedge ref_clk);
    bus_req <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req.enable <= 1'b1;
    #1;
    while (pready !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({31'h0, pready}, 32'h1, "bus ready");
    rq = prdata;
    re = pslverr;
    @(posedge ref_clk);
    bus_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q, err);
    chk({31'h0, err}, 32'h0, "write error");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0, q, err);
    chk(q, exp, m);
  endtask

  // wait a bounded time for one wake pulse: 2 supply, 1 radio, 0 core
  task automatic wait_pulse(input int idx, input int lim);
    int n;
    n = 0;
    cyc(1);
    while (wake[idx] !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    chk({31'h0, wake[idx]}, 32'h1, "wake pulse");
  endtask

  task automatic t_reset();
    for (int i = 0; i < 13; i++) begin
      rd(RST_OFF[i], RST_VAL[i], "reset value");
    end
    chk({31'h0, cpu_sleeping}, 32'h1, "cpu forced asleep");
  endtask

  task automatic t_refuse();
    bus(1'b0, 8'h04, 32'h0, q, err);
    chk({31'h0, err}, 32'h1, "unmapped read");
    chk(q, 32'h0, "unmapped data");
    bus(1'b1, 8'h0c, 32'h5a5a_5a5a, q, err);
    chk({31'h0, err}, 32'h1, "unmapped write");
    wr(`SWT_OFF_MIN, 32'hffff_ffff);
    rd(`SWT_OFF_MIN, 32'h0, "read-only min");
  endtask

  task automatic t_stats();
    cyc(1000);
    rd(`SWT_OFF_MIN, 32'h100, "min period");
    rd(`SWT_OFF_MAX, 32'h100, "max period");
    bus(1'b0, `SWT_OFF_MEAN, 32'h0, q, err);
    chk({18'h0, q[13:0]}, 32'h100, "mean period");
    @(posedge slow_clk);
    cyc(5);
    wr(`SWT_OFF_STCLR, 32'h3);
    rd(`SWT_OFF_STCLR, 32'h0, "clear bits self clear");
    rd(`SWT_OFF_MIN, 32'h0, "min cleared");
    rd(`SWT_OFF_MAX, 32'h0, "max cleared");
    rd(`SWT_OFF_MEAN, 32'h0, "mean cleared");
    cyc(13000);
    bus(1'b0, `SWT_OFF_MEAN, 32'h0, q, err);
    chk({24'h0, q[31:24]}, 32'hff, "count saturates");
    chk({18'h0, q[13:0]}, 32'h100, "mean after clear");
  endtask

  task automatic t_fraction();
    logic [31:0] prev;
    int steps;
    steps = 0;
    cyc(1);
    prev = free_time;
    repeat (100) begin
      cyc(1);
      if (free_time !== prev) begin
        steps++;
        chk(free_time, prev + 32'h1, "time step");
        prev = free_time;
      end
    end
    chk({31'h0, (steps inside {[29:35]})}, 32'h1, "steps in two periods");
  endtask

  task automatic t_radio();
    wr(`SWT_OFF_SETTLE, 32'hab00_0003);
    rd(`SWT_OFF_SETTLE, 32'hab00_0003, "lead time");
    bus(1'b0, `SWT_OFF_TIME, 32'h0, q, err);
    tgt = q[31:4] + 28'h8;
    wr(`SWT_OFF_RTIME, {tgt, 4'h9});
    rd(`SWT_OFF_RTIME, {tgt, 4'h9}, "radio target");
    wr(`SWT_OFF_RSLP, 32'h6000_0007);
    wait_pulse(2, 600);
    chk({4'h0, free_time[31:4]}, {4'h0, tgt - 28'h3}, "settle time");
    wait_pulse(1, 200);
    chk({4'h0, free_time[31:4]}, {4'h0, tgt}, "radio wake time");
    cyc(3);
    chk({31'h0, radio_lp_req}, 32'h0, "no request while busy");
    cyc(40);
    chk({31'h0, radio_lp_req}, 32'h1, "request when idle");
    chk({31'h0, radio_sleeping}, 32'h1, "sleep by handshake");
    rd(`SWT_OFF_RSLP, 32'h2000_0007, "enable cleared");
    rd(`SWT_OFF_RFLAG, 32'h1, "radio flag");
    chk({31'h0, radio_irq}, 32'h0, "radio irq masked");
    wr(`SWT_OFF_RMASK, 32'h1);
    cyc(3);
    chk({31'h0, radio_irq}, 32'h1, "radio irq");
    wr(`SWT_OFF_RFLAG, 32'h1);
    rd(`SWT_OFF_RFLAG, 32'h0, "radio flag cleared");
    cyc(2);
    chk({31'h0, radio_irq}, 32'h0, "radio irq gone");
  endtask

  task automatic t_core();
    wr(`SWT_OFF_CTIME, 32'hffff_ffff);
    rd(`SWT_OFF_CTIME, 32'hffff_fff0, "core target low bits");
    bus(1'b0, `SWT_OFF_TIME, 32'h0, q, err);
    tgt = q[31:4] + 28'h8;
    wr(`SWT_OFF_CTIME, {tgt, 4'h0});
    wr(`SWT_OFF_CSLP, 32'hc000_0007);
    wait_pulse(2, 600);
    chk({4'h0, free_time[31:4]}, {4'h0, tgt - 28'h3}, "core settle");
    wait_pulse(0, 200);
    chk({4'h0, free_time[31:4]}, {4'h0, tgt}, "core wake time");
    cyc(3);
    rd(`SWT_OFF_CFLAG, 32'h1, "core flag");
    chk({31'h0, core_irq}, 32'h0, "core irq masked");
    wr(`SWT_OFF_CMASK, 32'h1);
    cyc(3);
    chk({31'h0, core_irq}, 32'h1, "core irq");
    wr(`SWT_OFF_CFLAG, 32'h1);
    cyc(2);
    chk({31'h0, core_irq}, 32'h0, "core irq cleared");
    wr(`SWT_OFF_CSLP, 32'h0000_0007);
    cyc(2);
    chk({31'h0, cpu_sleeping}, 32'h0, "cpu awake");
    @(posedge ref_clk);
    cpu_sleep_req <= 1'b1;
    cyc(2);
    chk({31'h0, cpu_sleeping}, 32'h1, "cpu sleep handshake");
  endtask

  task automatic t_sleep();
    wr(`SWT_OFF_RSLP, 32'h8000_0007);
    cyc(2);
    chk({31'h0, radio_lp_req}, 32'h0, "sleep disabled");
    chk({31'h0, radio_sleeping}, 32'h1, "radio forced asleep");
    wr(`SWT_OFF_RSLP, 32'h2000_0007);
    @(posedge ref_clk);
    sequence_timer_two_en <= 1'b1;
    cyc(3);
    chk({31'h0, radio_lp_req}, 32'h0, "timer two busy");
    chk({31'h0, radio_sleeping}, 32'h0, "radio awake");
    @(posedge ref_clk);
    sequence_timer_two_en <= 1'b0;
    sequence_timer_one_en <= 1'b1;
    cyc(3);
    chk({31'h0, radio_lp_req}, 32'h0, "timer one busy");
    @(posedge ref_clk);
    sequence_timer_one_en <= 1'b0;
    cyc(3);
    chk({31'h0, radio_lp_req}, 32'h1, "idle request");
  endtask

  // main sequence
  initial begin
    ref_clk = 1'b0;
    slow_clk = 1'b0;
    reset_n = 1'b0;
    bus_req = '0;
    cpu_sleep_req = 1'b0;
    sequence_timer_one_en = 1'b0;
    sequence_timer_two_en = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(4);
    t_reset();
    t_refuse();
    t_stats();
    t_fraction();
    t_radio();
    t_core();
    t_sleep();
    close_out();
  end

  // watchdog well beyond the expected 15k cycles
  initial begin
    #(20 * 40000);
    errors++;
    close_out();
  end
endmodule // slow_clock_wakeup_timer_test
